// File: tofd_pkg.sv
// Shared constants, layouts and state types of the timer overflow frequency divider
`default_nettype none
package tofd_pkg;
	localparam logic [7:0] OFF_T0_CTRL = 8'h00;
	localparam logic [7:0] OFF_T0_COUNT = 8'h04;
	localparam logic [7:0] OFF_T1_CTRL = 8'h08;
	localparam logic [7:0] OFF_T1_COUNT = 8'h0C;
	localparam logic [7:0] OFF_CTRL_ZERO = 8'h10;
	localparam logic [7:0] OFF_CTRL_ONE = 8'h14;
	localparam logic [7:0] OFF_PORT_DATA = 8'h18;
	localparam logic [7:0] OFF_PORT_DIR = 8'h1C;
	localparam logic [7:0] OFF_INT_CTRL = 8'h20;
	localparam logic [7:0] OFF_POWER = 8'h24;
	localparam int TC_PSC_LSB = 0;
	localparam int TC_EDGE_BIT = 3;
	localparam int TC_RUN_BIT = 4;
	localparam int TC_SRC_BIT = 5;
	localparam int TC_MODE_LSB = 6;
	localparam int C0_PIN_EN_LSB = 0;
	localparam int C0_CLK_SEL_BIT = 2;
	localparam int INT_EN_LSB = 0;
	localparam int INT_FLAG_LSB = 4;
	localparam int PORT_PIN_LSB = 4;
	localparam logic [1:0] MODE_EVENT = 2'h1;
	localparam logic [1:0] MODE_PULSE = 2'h3;
	localparam logic [1:0] PIN_EN_NONE = 2'h0;
	localparam logic [1:0] PIN_EN_SINGLE = 2'h1;
	localparam logic [3:0] TB_TAP_0 = 4'hA;
	localparam logic [3:0] TB_TAP_1 = 4'hB;
	localparam logic [3:0] TB_TAP_2 = 4'hC;
	localparam logic [3:0] TB_TAP_3 = 4'hD;
	localparam logic [1:0] QUARTER_LAST = 2'h3;
	localparam logic [7:0] RST_T_CTRL = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [1:0] RST_PORT_DIR = 2'h3;
	localparam logic [7:0] COUNT_FULL = 8'hFF;

	typedef struct packed {
		logic [7:0] count;
		logic [7:0] preload;
		logic [7:0] psc_cnt;
		logic pin_prev;
		logic started;
		logic ovf;
		logic done;
	} tofd_cnt_s;

	typedef struct packed {
		logic [7:0] t0_ctrl;
		logic [7:0] t1_ctrl;
		logic [2:0] ctrl_zero;
		logic [1:0] ctrl_one;
		logic [1:0] port_data;
		logic [1:0] port_dir;
		logic [2:0] int_en;
		logic [2:0] int_flag;
		logic power_down;
		logic toggle;
		logic [12:0] tb_cnt;
		logic [1:0] quarter;
		logic [1:0] pin_out;
		logic [1:0] pin_oe_n;
		logic [2:0] irq;
		logic wake;
		logic ack;
		logic [31:0] rdata;
	} tofd_main_s;

	// Ones in the low n bits; n of 13 wraps to all ones
	function automatic logic [12:0] tofd_low_mask(input logic [3:0] n);
		tofd_low_mask = (13'h0001 << n) - 13'h0001;
	endfunction
endpackage
`default_nettype wire

// File: tofd_counter.sv
// One 8-bit up counter with preload, prescaler, event and pulse capture modes
`timescale 1ns/1ps
`default_nettype none
module tofd_counter
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic src_tick,
	input wire logic [2:0] psc_sel,
	input wire logic [1:0] mode,
	input wire logic edge_sel,
	input wire logic run,
	input wire logic hold,
	input wire logic preload_we,
	input wire logic [7:0] preload_data,
	input wire logic pin_in,
	output logic [7:0] count_out,
	output logic ovf_pulse,
	output logic capture_done
);
	import tofd_pkg::*;

	tofd_cnt_s r_reg;
	tofd_cnt_s r_next;
	logic tick;
	logic inc;
	logic event_edge;
	logic [7:0] psc_mask;
	logic [12:0] psc_wide;

	always_comb
	begin
		r_next = r_reg;
		r_next.ovf = 1'b0;
		r_next.done = 1'b0;
		r_next.pin_prev = pin_in;
		inc = 1'b0;
		psc_wide = tofd_low_mask({1'b0, psc_sel});
		psc_mask = psc_wide[7:0];
		if (src_tick)
			r_next.psc_cnt = r_reg.psc_cnt + 8'h01;
		// Pin is seen only on the timer's own tick in pulse mode; event mode sees it every cycle
		tick = src_tick && ((r_reg.psc_cnt & psc_mask) == psc_mask);
		event_edge = edge_sel ? (r_reg.pin_prev & ~pin_in) : (~r_reg.pin_prev & pin_in);
		// An access in progress stops counting; counts may be lost
		if (run && !hold)
		begin
			case (mode)
				MODE_PULSE:
				begin
					if (tick)
					begin
						if (pin_in == edge_sel)
						begin
							r_next.started = 1'b1;
							inc = 1'b1;
						end
						else if (r_reg.started)
						begin
							r_next.started = 1'b0;
							r_next.done = 1'b1;
						end
					end
				end
				MODE_EVENT:
					inc = event_edge;
				default:
					inc = tick;
			endcase
		end
		if (!run)
			r_next.started = 1'b0;
		if (inc)
		begin
			if (r_reg.count == COUNT_FULL)
			begin
				r_next.count = r_reg.preload;
				r_next.ovf = 1'b1;
			end
			else
				r_next.count = r_reg.count + 8'h01;
		end
		if (preload_we)
		begin
			r_next.preload = preload_data;
			if (!run)
				r_next.count = preload_data;
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			r_reg <= '{count: RST_COUNT, preload: RST_COUNT, psc_cnt: 8'h00, default: 1'b0};
		else if (clk_en)
			r_reg <= r_next;
	end

	assign count_out = r_reg.count;
	assign ovf_pulse = r_reg.ovf;
	assign capture_done = r_reg.done;

	property p_cnt_reload;
		@(posedge clock) disable iff (!resetn)
		(clk_en && inc && r_reg.count == COUNT_FULL) |=> (r_reg.count == $past(r_reg.preload) && r_reg.ovf);
	endproperty
	a_cnt_reload: assert property (p_cnt_reload) else $error("counter did not reload on full");

	property p_cnt_stop;
		@(posedge clock) disable iff (!resetn)
		(clk_en && (!run || hold) && !preload_we) |=> $stable(r_reg.count);
	endproperty
	a_cnt_stop: assert property (p_cnt_stop) else $error("counter moved while stopped or held");
endmodule
`default_nettype wire

// File: tofd_top.sv
// Timer pair, time base and overflow frequency divider with a Wishbone slave
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Divider clock is the overflow of counter 0 or 1, picked by select bit.
// - Each overflow of the chosen counter toggles the first divider output, and the second too in pair mode.
// - Counter counts up from preload, overflows when full, reloads and continues.
// - In pair mode the second output carries the inverse of the first while switched on.
// - Two-bit enable field: off, single output, or complementary pair.
// - Pin drives only when set as output; both inputs stops the divider.
// - Port data bit zero (dual) or one (single) switches the divider on.
// - With that data bit low every divider output is low.
// - In pulse mode external pin changes are seen only at the next timer tick; event mode sees them every clock.
// - Counter clock is inhibited while the count is read or preload written.
// - Overflow sets the counter flag; with enable set an interrupt is raised.
// - In power-down an overflow wakes the device whatever the enables.
// - No overflow wake-up if that counter flag was already set.
// - Counter runs while control bit 4 is set, stops when cleared.
// - Time base divides through 13 stages, ratio by two bits, timer-0 source.
// - Each time base time-out raises a time base request.
// - Control bits 7:6 pick mode; 11 is pulse width capture.
module tofd_top
#(
	parameter logic DUAL_OUTPUT = 1'b1
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [1:0] timer_input_pin,
	input wire logic [1:0] port_pin_in,
	output logic [1:0] freq_divider_out,
	output logic [1:0] freq_divider_oe_n,
	output logic timer0_irq,
	output logic timer1_irq,
	output logic timebase_irq,
	output logic wake_up
);
	import tofd_pkg::*;

	tofd_main_s r_reg;
	tofd_main_s r_next;
	logic req;
	logic wr;
	logic [7:0] wbyte;
	logic quarter_tick;
	logic [1:0] src_tick;
	logic [1:0] ovf;
	logic [1:0] done;
	logic [7:0] count0;
	logic [7:0] count1;
	logic [1:0] hold;
	logic [1:0] preload_we;
	logic [1:0] pin_enable;
	logic clock_select;
	logic on_bit;
	logic pin1_used;
	logic div_func;
	logic div_run;
	logic src_ovf;
	logic tb_tick;
	logic tb_timeout;
	logic [3:0] tb_tap;
	logic [12:0] tb_mask;
	logic [31:0] rd;

	assign req = wb_cyc_i && wb_stb_i && !r_reg.ack;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign wbyte = wb_dat_i[7:0];
	assign quarter_tick = (r_reg.quarter == QUARTER_LAST);
	assign src_tick[0] = r_reg.t0_ctrl[TC_SRC_BIT] ? quarter_tick : 1'b1;
	assign src_tick[1] = r_reg.t1_ctrl[TC_SRC_BIT] ? quarter_tick : 1'b1;
	// Held for the whole bus access, not just the acked cycle
	assign hold[0] = wb_cyc_i && wb_stb_i && (wb_adr_i == OFF_T0_COUNT);
	assign hold[1] = wb_cyc_i && wb_stb_i && (wb_adr_i == OFF_T1_COUNT);
	assign preload_we[0] = wr && (wb_adr_i == OFF_T0_COUNT);
	assign preload_we[1] = wr && (wb_adr_i == OFF_T1_COUNT);

	tofd_counter u_count0
	(
		.clock(clock),
		.resetn(resetn),
		.clk_en(clk_en),
		.src_tick(src_tick[0]),
		.psc_sel(r_reg.t0_ctrl[TC_PSC_LSB +: 3]),
		.mode(r_reg.t0_ctrl[TC_MODE_LSB +: 2]),
		.edge_sel(r_reg.t0_ctrl[TC_EDGE_BIT]),
		.run(r_reg.t0_ctrl[TC_RUN_BIT]),
		.hold(hold[0]),
		.preload_we(preload_we[0]),
		.preload_data(wbyte),
		.pin_in(timer_input_pin[0]),
		.count_out(count0),
		.ovf_pulse(ovf[0]),
		.capture_done(done[0])
	);

	tofd_counter u_count1
	(
		.clock(clock),
		.resetn(resetn),
		.clk_en(clk_en),
		.src_tick(src_tick[1]),
		.psc_sel(r_reg.t1_ctrl[TC_PSC_LSB +: 3]),
		.mode(r_reg.t1_ctrl[TC_MODE_LSB +: 2]),
		.edge_sel(r_reg.t1_ctrl[TC_EDGE_BIT]),
		.run(r_reg.t1_ctrl[TC_RUN_BIT]),
		.hold(hold[1]),
		.preload_we(preload_we[1]),
		.preload_data(wbyte),
		.pin_in(timer_input_pin[1]),
		.count_out(count1),
		.ovf_pulse(ovf[1]),
		.capture_done(done[1])
	);

	always_comb
	begin
		pin_enable = r_reg.ctrl_zero[C0_PIN_EN_LSB +: 2];
		clock_select = r_reg.ctrl_zero[C0_CLK_SEL_BIT];
		on_bit = DUAL_OUTPUT ? r_reg.port_data[0] : r_reg.port_data[1];
		div_func = (pin_enable != PIN_EN_NONE);
		pin1_used = div_func && DUAL_OUTPUT && (pin_enable != PIN_EN_SINGLE);
		// With no pin set as output the divider stands still
		div_run = div_func && (!r_reg.port_dir[0] || (pin1_used && !r_reg.port_dir[1]));
		src_ovf = clock_select ? ovf[1] : ovf[0];
		tb_tick = r_reg.t0_ctrl[TC_SRC_BIT] ? quarter_tick : 1'b1;
		case (r_reg.ctrl_one)
			2'h0: tb_tap = TB_TAP_0;
			2'h1: tb_tap = TB_TAP_1;
			2'h2: tb_tap = TB_TAP_2;
			default: tb_tap = TB_TAP_3;
		endcase
		tb_mask = tofd_low_mask(tb_tap);
		tb_timeout = tb_tick && ((r_reg.tb_cnt & tb_mask) == tb_mask);
		case (wb_adr_i)
			OFF_T0_CTRL: rd = {24'h0000_00, r_reg.t0_ctrl};
			OFF_T0_COUNT: rd = {24'h0000_00, count0};
			OFF_T1_CTRL: rd = {24'h0000_00, r_reg.t1_ctrl};
			OFF_T1_COUNT: rd = {24'h0000_00, count1};
			OFF_CTRL_ZERO: rd = {29'h0000_0000, r_reg.ctrl_zero};
			OFF_CTRL_ONE: rd = {30'h0000_0000, r_reg.ctrl_one};
			OFF_PORT_DATA: rd = {26'h0000_000, port_pin_in, 2'h0, r_reg.port_data};
			OFF_PORT_DIR: rd = {30'h0000_0000, r_reg.port_dir};
			OFF_INT_CTRL: rd = {25'h0000_000, r_reg.int_flag, 1'b0, r_reg.int_en};
			OFF_POWER: rd = {31'h0000_0000, r_reg.power_down};
			default: rd = 32'h0000_0000;
		endcase
	end

	always_comb
	begin
		r_next = r_reg;
		r_next.ack = req;
		r_next.wake = 1'b0;
		r_next.quarter = r_reg.quarter + 2'h1;
		if (req)
			r_next.rdata = rd;
		if (wr)
		begin
			case (wb_adr_i)
				OFF_T0_CTRL: r_next.t0_ctrl = wbyte;
				OFF_T1_CTRL: r_next.t1_ctrl = wbyte;
				OFF_CTRL_ZERO: r_next.ctrl_zero = wbyte[2:0];
				OFF_CTRL_ONE: r_next.ctrl_one = wbyte[1:0];
				OFF_PORT_DATA: r_next.port_data = wbyte[1:0];
				OFF_PORT_DIR: r_next.port_dir = wbyte[1:0];
				OFF_INT_CTRL:
				begin
					r_next.int_en = wbyte[INT_EN_LSB +: 3];
					r_next.int_flag = wbyte[INT_FLAG_LSB +: 3];
				end
				OFF_POWER: r_next.power_down = wbyte[0];
				default: r_next.power_down = r_reg.power_down;
			endcase
		end
		// Capture end clears the run bit unless software writes it in the same cycle
		if (done[0] && !(wr && wb_adr_i == OFF_T0_CTRL))
			r_next.t0_ctrl[TC_RUN_BIT] = 1'b0;
		if (done[1] && !(wr && wb_adr_i == OFF_T1_CTRL))
			r_next.t1_ctrl[TC_RUN_BIT] = 1'b0;
		// Hardware set wins over a clearing write
		r_next.int_flag = r_next.int_flag | {tb_timeout, ovf};
		if (tb_tick)
			r_next.tb_cnt = r_reg.tb_cnt + 13'h0001;
		// Old flag value decides, so a flag set before halt masks the wake
		if (r_reg.power_down && ((ovf[0] && !r_reg.int_flag[0]) || (ovf[1] && !r_reg.int_flag[1])))
		begin
			r_next.wake = 1'b1;
			r_next.power_down = 1'b0;
		end
		r_next.irq = r_reg.int_flag & r_reg.int_en;
		if (!div_func)
			r_next.toggle = 1'b0;
		else if (div_run && src_ovf)
			r_next.toggle = ~r_reg.toggle;
		r_next.pin_oe_n = r_reg.port_dir;
		r_next.pin_out[0] = div_func ? (r_reg.toggle && on_bit) : r_reg.port_data[0];
		r_next.pin_out[1] = pin1_used ? (!r_reg.toggle && on_bit) : r_reg.port_data[1];
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			r_reg <= '{t0_ctrl: RST_T_CTRL, t1_ctrl: RST_T_CTRL, port_dir: RST_PORT_DIR,
				pin_oe_n: RST_PORT_DIR, default: '0};
		else if (clk_en)
			r_reg <= r_next;
	end

	assign wb_dat_o = r_reg.rdata;
	assign wb_ack_o = r_reg.ack;
	assign freq_divider_out = r_reg.pin_out;
	assign freq_divider_oe_n = r_reg.pin_oe_n;
	assign timer0_irq = r_reg.irq[0];
	assign timer1_irq = r_reg.irq[1];
	assign timebase_irq = r_reg.irq[2];
	assign wake_up = r_reg.wake;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	property p_toggle;
		(clk_en && div_run && src_ovf) |=> (r_reg.toggle != $past(r_reg.toggle));
	endproperty
	a_toggle: assert property (p_toggle) else $error("divider did not toggle on overflow");

	property p_source;
		(clk_en && div_run && !clock_select && ovf[1] && !ovf[0]) |=> $stable(r_reg.toggle);
	endproperty
	a_source: assert property (p_source) else $error("unselected counter toggled divider");

	property p_complement;
		(clk_en && pin1_used && on_bit && $stable(r_reg.toggle)) |=>
			(r_reg.pin_out[1] == !r_reg.pin_out[0]);
	endproperty
	a_complement: assert property (p_complement) else $error("pair not complementary");

	property p_off_low;
		(clk_en && div_func && !on_bit) |=> (r_reg.pin_out[0] == 1'b0);
	endproperty
	a_off_low: assert property (p_off_low) else $error("divider output high while off");

	property p_direction;
		clk_en |=> (freq_divider_oe_n == $past(r_reg.port_dir));
	endproperty
	a_direction: assert property (p_direction) else $error("pin drive ignores direction");

	property p_deselect;
		(clk_en && !div_func) |=> (freq_divider_out == $past(r_reg.port_data));
	endproperty
	a_deselect: assert property (p_deselect) else $error("deselected pin not plain port");

	property p_flag;
		(clk_en && ovf[0]) |=> r_reg.int_flag[0] ##1
			(!$past(clk_en) || r_reg.irq[0] == $past(r_reg.int_en[0]));
	endproperty
	a_flag: assert property (p_flag) else $error("overflow flag or interrupt missing");

	property p_wake;
		(clk_en && r_reg.power_down && ovf[0] && !r_reg.int_flag[0]) |=> (wake_up && !r_reg.power_down);
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on overflow in power-down");

	property p_no_wake;
		(clk_en && r_reg.int_flag[0] && !ovf[1]) |=> !wake_up;
	endproperty
	a_no_wake: assert property (p_no_wake) else $error("wake despite flags already set");

	property p_timebase;
		(clk_en && tb_timeout) |=> r_reg.int_flag[2];
	endproperty
	a_timebase: assert property (p_timebase) else $error("time base request missing");

	property p_ack_drop;
		(clk_en && wb_ack_o) |=> !wb_ack_o;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack held more than one cycle");

	c_toggle: cover property (clk_en && div_run && src_ovf && pin1_used);
	c_wake: cover property (clk_en && wake_up);
	c_capture: cover property (clk_en && done[0]);
	c_timebase: cover property (clk_en && tb_timeout && r_reg.ctrl_one == 2'h0);
endmodule
`default_nettype wire

// File: tofd_buzzer.sv
// Far-side model: buzzer on the divider pins and pulse source on the timer pins
`timescale 1ns/1ps
`default_nettype none
module tofd_buzzer
(
	input wire logic clock,
	input wire logic [1:0] freq_divider_out,
	input wire logic [1:0] freq_divider_oe_n,
	output logic [1:0] timer_input_pin,
	output int edge_cnt,
	output int pair_err
);
	logic prev;
	initial
	begin
		// Pull-high stays on while the pins serve as timer inputs
		timer_input_pin = 2'b11;
		edge_cnt = 0;
		pair_err = 0;
		prev = 1'b0;
	end
	always @(posedge clock)
	begin
		if (freq_divider_out[0] === 1'b1 && prev !== 1'b1)
			edge_cnt <= edge_cnt + 1;
		// Both pins high while both drive would short the piezo
		if (freq_divider_oe_n === 2'b00 && freq_divider_out === 2'b11)
			pair_err <= pair_err + 1;
		prev <= freq_divider_out[0];
	end
	// Low pulse, levels held long enough to be seen at a timer tick
	task automatic pulse(input int ch);
		@(posedge clock);
		timer_input_pin[ch] <= 1'b0;
		repeat (3) @(posedge clock);
		timer_input_pin[ch] <= 1'b1;
		repeat (3) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// File: tofd_top_bench.sv
// Self-checking bench of the overflow frequency divider and its timers
`timescale 1ns/1ps
`default_nettype none
module tofd_top_bench;
	import tofd_pkg::*;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic ce = 1'b1;
	logic [3:0] sel = 4'h0;
	logic [1:0] ppin = 2'b01;
	time t_first;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic ack;
	logic [1:0] tpin;
	logic [1:0] fout;
	logic [1:0] foe_n;
	logic t0_irq;
	logic t1_irq;
	logic tb_irq;
	logic wake;
	int edge_cnt;
	int pair_err;
	int wake_cnt = 0;
	int error_cnt = 0;
	int num_checks = 0;
	logic [7:0] q;
	logic [7:0] q2;
	int e0;
	tofd_top i_tofd_top (.clock(clock), .resetn(resetn), .clk_en(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .timer_input_pin(tpin), .port_pin_in(ppin),
		.freq_divider_out(fout), .freq_divider_oe_n(foe_n), .timer0_irq(t0_irq),
		.timer1_irq(t1_irq), .timebase_irq(tb_irq), .wake_up(wake));
	tofd_buzzer i_tofd_buzzer (.clock(clock), .freq_divider_out(fout),
		.freq_divider_oe_n(foe_n), .timer_input_pin(tpin), .edge_cnt(edge_cnt),
		.pair_err(pair_err));
	always #25 clock = ~clock;
	always @(posedge clock)
		if (wake === 1'b1)
			wake_cnt <= wake_cnt + 1;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'h1;
		adr <= a;
		wdat <= {24'h00_0000, d};
		// Only the watchdog ends a wait for ack
		do
		begin
			@(posedge clock);
		end
		while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		sel <= 4'h0;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		xfer(1'b0, a, 8'h00);
		chk(what, exp, q);
	endtask
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge clock);
		error_cnt++;
		test_done();
	end
	initial
	begin
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		chk("oe_n", 8'h03, {6'h00, foe_n});
		rd(OFF_PORT_DIR, 8'h03, "port_dir");
		rd(OFF_PORT_DATA, 8'h10, "port_data");
		ppin <= 2'b10;
		rd(OFF_PORT_DATA, 8'h20, "port pins in");
		// Longest tap keeps time base flags out of the early tests
		xfer(1'b1, OFF_CTRL_ONE, 8'h03);
		rd(OFF_CTRL_ONE, 8'h03, "tb select");
		rd(OFF_T0_CTRL, 8'h00, "t0_ctrl");
		rd(8'h80, 8'h00, "unmapped");
		$display("Test reset done");
		xfer(1'b1, OFF_T0_COUNT, 8'hF0);
		xfer(1'b1, OFF_T0_CTRL, 8'h10);
		repeat (4)
		begin
			xfer(1'b0, OFF_T0_COUNT, 8'h00);
			chk("reload floor", 8'h01, {7'h00, q >= 8'hF0});
		end
		// Reads stall the count, so give it time to overflow
		repeat (20) @(posedge clock);
		rd(OFF_INT_CTRL, 8'h10, "t0 flag");
		xfer(1'b1, OFF_INT_CTRL, 8'h11);
		repeat (3) @(posedge clock);
		chk("t0 irq", 8'h01, {7'h00, t0_irq});
		xfer(1'b1, OFF_T0_CTRL, 8'h00);
		xfer(1'b0, OFF_T0_COUNT, 8'h00);
		q2 = q;
		repeat (10) @(posedge clock);
		rd(OFF_T0_COUNT, q2, "stopped count");
		$display("Test timer done");
		xfer(1'b1, OFF_INT_CTRL, 8'h00);
		xfer(1'b1, OFF_T0_COUNT, 8'hFC);
		xfer(1'b1, OFF_CTRL_ZERO, 8'h02);
		xfer(1'b1, OFF_PORT_DIR, 8'h00);
		xfer(1'b1, OFF_PORT_DATA, 8'h01);
		xfer(1'b1, OFF_T0_CTRL, 8'h10);
		e0 = edge_cnt;
		repeat (200) @(posedge clock);
		chk("edges 200", 8'h01, {7'h00, (edge_cnt - e0) inside {[24:26]}});
		chk("pair", 8'h00, pair_err[7:0]);
		chk("oe_n drive", 8'h00, {6'h00, foe_n});
		ce <= 1'b0;
		repeat (2) @(posedge clock);
		e0 = edge_cnt;
		repeat (20) @(posedge clock);
		chk("frozen edges", 8'h00, 8'(edge_cnt - e0));
		ce <= 1'b1;
		xfer(1'b1, OFF_CTRL_ZERO, 8'h06);
		repeat (3) @(posedge clock);
		e0 = edge_cnt;
		repeat (100) @(posedge clock);
		chk("ctr1 edges", 8'h00, 8'(edge_cnt - e0));
		xfer(1'b1, OFF_CTRL_ZERO, 8'h02);
		xfer(1'b1, OFF_PORT_DIR, 8'h03);
		repeat (3) @(posedge clock);
		e0 = edge_cnt;
		repeat (100) @(posedge clock);
		chk("inputs edges", 8'h00, 8'(edge_cnt - e0));
		xfer(1'b1, OFF_PORT_DIR, 8'h00);
		xfer(1'b1, OFF_PORT_DATA, 8'h00);
		repeat (3) @(posedge clock);
		repeat (20)
		begin
			@(posedge clock);
			chk("off low", 8'h00, {6'h00, fout});
		end
		xfer(1'b1, OFF_CTRL_ZERO, 8'h00);
		xfer(1'b1, OFF_PORT_DATA, 8'h02);
		repeat (3) @(posedge clock);
		chk("port pins", 8'h02, {6'h00, fout});
		$display("Test divider done");
		xfer(1'b1, OFF_T0_CTRL, 8'h00);
		xfer(1'b1, OFF_T0_COUNT, 8'hFE);
		xfer(1'b1, OFF_INT_CTRL, 8'h00);
		xfer(1'b1, OFF_POWER, 8'h01);
		xfer(1'b1, OFF_T0_CTRL, 8'h10);
		repeat (10) @(posedge clock);
		chk("wake", 8'h01, 8'(wake_cnt));
		rd(OFF_POWER, 8'h00, "power after wake");
		xfer(1'b1, OFF_T0_CTRL, 8'h00);
		xfer(1'b1, OFF_INT_CTRL, 8'h10);
		xfer(1'b1, OFF_POWER, 8'h01);
		xfer(1'b1, OFF_T0_CTRL, 8'h10);
		repeat (10) @(posedge clock);
		chk("no wake", 8'h01, 8'(wake_cnt));
		xfer(1'b1, OFF_T0_CTRL, 8'h00);
		xfer(1'b1, OFF_POWER, 8'h00);
		$display("Test wake done");
		xfer(1'b1, OFF_T1_CTRL, 8'h40);
		xfer(1'b1, OFF_T1_COUNT, 8'hFE);
		xfer(1'b1, OFF_INT_CTRL, 8'h00);
		xfer(1'b1, OFF_T1_CTRL, 8'h50);
		i_tofd_buzzer.pulse(1);
		rd(OFF_T1_COUNT, 8'hFF, "event one");
		i_tofd_buzzer.pulse(1);
		rd(OFF_T1_COUNT, 8'hFE, "event reload");
		rd(OFF_INT_CTRL, 8'h20, "t1 flag");
		chk("t1 irq masked", 8'h00, {7'h00, t1_irq});
		xfer(1'b1, OFF_T1_CTRL, 8'h40);
		i_tofd_buzzer.pulse(1);
		rd(OFF_T1_COUNT, 8'hFE, "event stopped");
		$display("Test event done");
		xfer(1'b1, OFF_T0_COUNT, 8'h00);
		xfer(1'b1, OFF_T0_CTRL, 8'hD0);
		i_tofd_buzzer.pulse(0);
		rd(OFF_T0_COUNT, 8'h03, "capture width");
		rd(OFF_T0_CTRL, 8'hC0, "capture run clear");
		$display("Test capture done");
		xfer(1'b1, OFF_CTRL_ONE, 8'h00);
		xfer(1'b1, OFF_INT_CTRL, 8'h04);
		e0 = 0;
		while (tb_irq !== 1'b1 && e0 < 1100)
		begin
			@(posedge clock);
			e0++;
		end
		chk("tb irq", 8'h01, {7'h00, tb_irq === 1'b1});
		t_first = $time;
		xfer(1'b1, OFF_INT_CTRL, 8'h04);
		repeat (2) @(posedge clock);
		while (tb_irq !== 1'b1)
			@(posedge clock);
		chk("tb period", 8'h01, {7'h00, ($time - t_first) == (64'd50 << TB_TAP_0)});
		$display("Test time base done");
		test_done();
	end
endmodule
`default_nettype wire
